// [hpcr_bank.sv]
// hpcr_bank: hub port configuration registers at offsets 6h to ah
// Overview of operation
// - charge enable one turns port charging on
// - charge enables captured from straps at release
// - eeprom or smbus may replace charge enables
// - charge register bits 7:2 read zero
// - override set: removability from register bits
// - override clear: bits locked, read inverted otp
// - bits 3:2 writable read zero; 6:2 zero
// - i2c mode loads eeprom, smbus mode host writes
`timescale 1ns/1ns
`default_nettype none
module hpcr_bank (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  // straps and otp
  input wire logic [1:0] power_charge_strap_pins_in,
  input wire logic pwr_pol_strap_in,
  input wire logic [1:0] otp_non_removable_in,
  input wire logic otp_hicur_in,
  input wire logic otp_auto_dis_in,
  // configuration mode, 1 = i2c eeprom load, 0 = smbus host
  input wire logic i2c_mode_in,
  // eeprom loader writes
  input wire logic eeprom_wr_in,
  input wire logic [7:0] eeprom_addr_in,
  input wire logic [7:0] eeprom_data_in,
  // smbus host writes and reads
  input wire logic smbus_wr_in,
  input wire logic smbus_rd_in,
  input wire logic [7:0] smbus_addr_in,
  input wire logic [7:0] smbus_data_in,
  // read answer
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  // port controls
  output logic [1:0] charge_port_enable_out,
  output logic [1:0] port_removable_out,
  output logic [7:0] phy_tuning_out,
  output logic [7:0] dev_cfg2_out
);
  // ==========================================================================
  // state
  hpcr_pkg::hpcr_phase_t phase_ff, nxt_phase; // strap capture then run
  logic [1:0] charge_en_ff, nxt_charge_en; // per port charging enable
  logic rem_ovr_ff, nxt_rem_ovr; // removable_override
  logic [1:0] rmbl_ff, nxt_rmbl; // software removable bits
  logic [7:0] phy_ff, nxt_phy; // phy tuning writable bits
  logic [7:0] cfg2_ff, nxt_cfg2; // stored second config bits
  logic [1:0] port_rmbl_ff, nxt_port_rmbl; // reported removability
  logic [7:0] rd_data_ff, nxt_rd_data; // read answer
  logic rd_valid_ff, nxt_rd_valid; // read answer strobe
  logic [7:0] cfg2_view_ff, nxt_cfg2_view; // second config as read
  logic wr_en; // selected write strobe
  logic [7:0] wr_addr; // selected write offset
  logic [7:0] wr_data; // selected write data
  // ==========================================================================
  // second config as seen: otp bits shown unless custom enabled
  function automatic logic [7:0] cfg2_view(input logic [7:0] stored, input logic hicur,
                                           input logic auto_dis);
    logic [7:0] v;
    v = stored;
    if (!stored[hpcr_pkg::CFG2_BCCUST_BIT]) begin
      v[hpcr_pkg::CFG2_HICUR_BIT] = hicur;
      v[hpcr_pkg::CFG2_AUTO_BIT] = auto_dis;
    end
    return v;
  endfunction
  // ==========================================================================
  // write source
  hpcr_wr_select u_wr_select (
    .i2c_mode_in(i2c_mode_in),
    .eeprom_wr_in(eeprom_wr_in),
    .eeprom_addr_in(eeprom_addr_in),
    .eeprom_data_in(eeprom_data_in),
    .smbus_wr_in(smbus_wr_in),
    .smbus_addr_in(smbus_addr_in),
    .smbus_data_in(smbus_data_in),
    .wr_en_out(wr_en),
    .wr_addr_out(wr_addr),
    .wr_data_out(wr_data)
  );
  // ==========================================================================
  // next state of the bank
  always_comb begin
    nxt_phase = phase_ff;
    nxt_charge_en = charge_en_ff;
    nxt_rem_ovr = rem_ovr_ff;
    nxt_rmbl = rmbl_ff;
    nxt_phy = phy_ff;
    nxt_cfg2 = cfg2_ff;
    case (phase_ff)
      hpcr_pkg::PH_STRAP: begin
        // first edge after release: straps land, writes wait one cycle
        nxt_charge_en = power_charge_strap_pins_in;
        nxt_cfg2[hpcr_pkg::CFG2_POL_BIT] = ~pwr_pol_strap_in;
        nxt_phase = hpcr_pkg::PH_RUN;
      end
      hpcr_pkg::PH_RUN: begin
        if (wr_en) begin
          case (wr_addr)
            hpcr_pkg::OFS_CHARGE: begin
              // only bits 1:0 stored, upper bits dropped
              nxt_charge_en = wr_data[1:0];
            end
            hpcr_pkg::OFS_REMOV: begin
              nxt_rem_ovr = wr_data[hpcr_pkg::REM_OVR_BIT];
              // bits 3:2 accept the write but hold nothing
              if (wr_data[hpcr_pkg::REM_OVR_BIT]) begin
                nxt_rmbl = wr_data[1:0];
              end
              // removable bits locked while override clear
            end
            hpcr_pkg::OFS_PHY: begin
              // reserved tuning bits keep their old value, writes never reach them
              nxt_phy = (phy_ff & ~hpcr_pkg::PHY_WMASK) | (wr_data & hpcr_pkg::PHY_WMASK);
            end
            hpcr_pkg::OFS_CFG2: begin
              nxt_cfg2 = (cfg2_ff & ~hpcr_pkg::CFG2_WMASK) | (wr_data & hpcr_pkg::CFG2_WMASK);
              // otp backed bits writable with custom bit, even in same write
              if (wr_data[hpcr_pkg::CFG2_BCCUST_BIT]) begin
                nxt_cfg2 = (nxt_cfg2 & ~hpcr_pkg::CFG2_OTP_MASK)
                           | (wr_data & hpcr_pkg::CFG2_OTP_MASK);
              end
            end
            default: begin
              // port used and unmapped offsets ignore writes
              nxt_phase = hpcr_pkg::PH_RUN;
            end
          endcase
        end
      end
      default: begin
        nxt_phase = hpcr_pkg::PH_STRAP;
      end
    endcase
  end
  // ==========================================================================
  // next state of reads and reported views
  always_comb begin
    // removability from register or inverted otp
    nxt_port_rmbl = rem_ovr_ff ? rmbl_ff : ~otp_non_removable_in;
    nxt_cfg2_view = cfg2_view(cfg2_ff, otp_hicur_in, otp_auto_dis_in);
    nxt_rd_valid = smbus_rd_in;
    nxt_rd_data = rd_data_ff;
    if (smbus_rd_in) begin
      case (smbus_addr_in)
        hpcr_pkg::OFS_CHARGE: nxt_rd_data = {6'h00, charge_en_ff};
        hpcr_pkg::OFS_REMOV: begin
          // bits 6:2 read zero; rmbl field follows override
          nxt_rd_data = {rem_ovr_ff, 5'h00, nxt_port_rmbl};
        end
        hpcr_pkg::OFS_PORTUSED: nxt_rd_data = hpcr_pkg::PORTUSED_RST;
        hpcr_pkg::OFS_PHY: nxt_rd_data = phy_ff;
        hpcr_pkg::OFS_CFG2: nxt_rd_data = nxt_cfg2_view;
        default: nxt_rd_data = hpcr_pkg::UNMAPPED_RD;
      endcase
    end
  end
  // ==========================================================================
  // registers
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      phase_ff <= hpcr_pkg::PH_STRAP;
      charge_en_ff <= hpcr_pkg::CHARGE_RST;
      rem_ovr_ff <= 1'b0;
      rmbl_ff <= hpcr_pkg::RMBL_RST;
      phy_ff <= hpcr_pkg::PHY_RST;
      cfg2_ff <= hpcr_pkg::CFG2_RST;
      port_rmbl_ff <= hpcr_pkg::RMBL_RST;
      rd_data_ff <= hpcr_pkg::UNMAPPED_RD;
      rd_valid_ff <= 1'b0;
      cfg2_view_ff <= hpcr_pkg::CFG2_RST;
    end else begin
      phase_ff <= nxt_phase;
      charge_en_ff <= nxt_charge_en;
      rem_ovr_ff <= nxt_rem_ovr;
      rmbl_ff <= nxt_rmbl;
      phy_ff <= nxt_phy;
      cfg2_ff <= nxt_cfg2;
      port_rmbl_ff <= nxt_port_rmbl;
      rd_data_ff <= nxt_rd_data;
      rd_valid_ff <= nxt_rd_valid;
      cfg2_view_ff <= nxt_cfg2_view;
    end
  end
  // ==========================================================================
  // outputs, each straight from a flip-flop
  assign charge_port_enable_out = charge_en_ff; // one enables charging
  assign port_removable_out = port_rmbl_ff;
  assign phy_tuning_out = phy_ff;
  assign dev_cfg2_out = cfg2_view_ff;
  assign rd_data_out = rd_data_ff;
  assign rd_valid_out = rd_valid_ff;
  // ==========================================================================
  // assertions
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  sequence s_run_wr(logic [7:0] ofs);
    phase_ff == hpcr_pkg::PH_RUN && wr_en && wr_addr == ofs;
  endsequence
  sequence s_read(logic [7:0] ofs);
    smbus_rd_in && smbus_addr_in == ofs;
  endsequence
  chk_strap_capture: assert property (
    phase_ff == hpcr_pkg::PH_STRAP |=> phase_ff == hpcr_pkg::PH_RUN
      && charge_port_enable_out == $past(power_charge_strap_pins_in))
    else $error("charge enables not taken from straps");
  chk_charge_write: assert property (
    s_run_wr(hpcr_pkg::OFS_CHARGE) |=> charge_port_enable_out == $past(wr_data[1:0]))
    else $error("charge enable write lost");
  chk_charge_upper_zero: assert property (
    s_read(hpcr_pkg::OFS_CHARGE) |=> rd_valid_out && rd_data_out[7:2] == 6'h00
      && rd_data_out[1:0] == $past(charge_en_ff))
    else $error("charge register read wrong");
  chk_rmbl_override: assert property (
    rem_ovr_ff |=> port_removable_out == $past(rmbl_ff))
    else $error("override removability not reported");
  chk_rmbl_from_otp: assert property (
    !rem_ovr_ff |=> port_removable_out == ~$past(otp_non_removable_in))
    else $error("otp removability not inverted");
  chk_rmbl_locked: assert property (
    s_run_wr(hpcr_pkg::OFS_REMOV) ##0 !wr_data[hpcr_pkg::REM_OVR_BIT] |=> $stable(rmbl_ff))
    else $error("removable bits changed while locked");
  chk_remov_rsvd_zero: assert property (
    s_read(hpcr_pkg::OFS_REMOV) |=> rd_data_out[6:2] == 5'h00
      && rd_data_out[7] == $past(rem_ovr_ff))
    else $error("removable register reserved bits not zero");
  chk_portused_ro: assert property (
    s_read(hpcr_pkg::OFS_PORTUSED) |=> rd_data_out == hpcr_pkg::PORTUSED_RST)
    else $error("port used register not read only");
  chk_mode_source: assert property (
    phase_ff == hpcr_pkg::PH_RUN && i2c_mode_in && !eeprom_wr_in && smbus_wr_in
      |=> $stable(charge_en_ff) && $stable(rem_ovr_ff))
    else $error("smbus write accepted in i2c mode");
endmodule // hpcr_bank
`default_nettype wire

// [hpcr_host_model.sv]
// hpcr_host_model: smbus host and eeprom loader driving the port config bank
`timescale 1ns/1ns
`default_nettype none
module hpcr_host_model (
  // clock
  input wire logic clk_sys_in,
  // read answer from the bank
  input wire logic [7:0] rd_data_in,
  input wire logic rd_valid_in,
  // eeprom loader side
  output logic eeprom_wr_out,
  output logic [7:0] eeprom_addr_out,
  output logic [7:0] eeprom_data_out,
  // smbus host side
  output logic smbus_wr_out,
  output logic smbus_rd_out,
  output logic [7:0] smbus_addr_out,
  output logic [7:0] smbus_data_out
);
  // idle strobes low, released lines wander
  initial begin
    {eeprom_wr_out, eeprom_addr_out, eeprom_data_out} = {1'b0, 8'h5a, 8'ha5};
    {smbus_wr_out, smbus_rd_out, smbus_addr_out, smbus_data_out} = {2'b00, 8'h3c, 8'hc3};
  end
  // one byte per strobe; released lines show the inverse of the last value
  task automatic wr(input logic src_eep, input logic [7:0] addr, input logic [7:0] data);
    logic [7:0] d;
    d = (addr == hpcr_pkg::OFS_PHY) ? (data & ~hpcr_pkg::PHY_WMASK) : data;
    @(negedge clk_sys_in);
    if (src_eep) begin
      {eeprom_wr_out, eeprom_addr_out, eeprom_data_out} = {1'b1, addr, d};
    end else begin
      {smbus_wr_out, smbus_addr_out, smbus_data_out} = {1'b1, addr, d};
    end
    @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    if (src_eep) begin
      {eeprom_wr_out, eeprom_addr_out, eeprom_data_out} = {1'b0, ~addr, ~d};
    end else begin
      {smbus_wr_out, smbus_addr_out, smbus_data_out} = {1'b0, ~addr, ~d};
    end
  endtask
  // read strobe, answer registered at the taking edge, sampled half a cycle later
  task automatic rd(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    @(negedge clk_sys_in);
    {smbus_rd_out, smbus_addr_out} = {1'b1, addr};
    @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    // valid stands only from the taking edge to the next one: look now
    ok = (rd_valid_in === 1'b1);
    data = rd_data_in;
    {smbus_rd_out, smbus_addr_out} = {1'b0, ~addr};
  endtask
endmodule // hpcr_host_model
`default_nettype wire

// [hpcr_pkg.sv]
// hpcr_pkg: offsets, field positions, reset values and phases of the port config bank
package hpcr_pkg;
  // ==========================================================================
  // register offsets
  localparam logic [7:0] OFS_CHARGE = 8'h06; // charging_port_support
  localparam logic [7:0] OFS_REMOV = 8'h07; // removable_port_config
  localparam logic [7:0] OFS_PORTUSED = 8'h08; // port_used_config
  localparam logic [7:0] OFS_PHY = 8'h09; // phy_tuning_config
  localparam logic [7:0] OFS_CFG2 = 8'h0a; // device_config_second
  // ==========================================================================
  // field positions
  localparam int REM_OVR_BIT = 7; // removable_override
  localparam int CFG2_BCCUST_BIT = 6; // custom charging features enable
  localparam int CFG2_POL_BIT = 5; // power enable polarity
  localparam int CFG2_HICUR_BIT = 4; // high current mode enable
  localparam int CFG2_AUTO_BIT = 1; // automatic mode disable
  // ==========================================================================
  // write masks (bits that accept a write)
  localparam logic [7:0] PHY_WMASK = 8'h23; // bit 5 and bits 1:0
  localparam logic [7:0] CFG2_WMASK = 8'h6c; // bits 6,5,3,2 always writable
  localparam logic [7:0] CFG2_OTP_MASK = 8'h12; // bits 4,1 writable when custom
  // ==========================================================================
  // reset values
  localparam logic [1:0] CHARGE_RST = 2'h0; // replaced by strap after release
  localparam logic [1:0] RMBL_RST = 2'h0;
  localparam logic [7:0] PORTUSED_RST = 8'h00;
  localparam logic [7:0] PHY_RST = 8'h00;
  localparam logic [7:0] CFG2_RST = 8'h00; // polarity bit replaced by strap
  localparam logic [7:0] UNMAPPED_RD = 8'h00;
  // ==========================================================================
  // bank phases
  typedef enum logic [0:0] {
    PH_STRAP = 1'b0, // first edge after reset release: take straps
    PH_RUN = 1'b1 // normal operation: loads and writes accepted
  } hpcr_phase_t;
endpackage

// [hpcr_wr_select.sv]
// hpcr_wr_select: picks the write source of the bank by configuration mode
`timescale 1ns/1ns
`default_nettype none
module hpcr_wr_select (
  // mode
  input wire logic i2c_mode_in,
  // eeprom loader
  input wire logic eeprom_wr_in,
  input wire logic [7:0] eeprom_addr_in,
  input wire logic [7:0] eeprom_data_in,
  // smbus host
  input wire logic smbus_wr_in,
  input wire logic [7:0] smbus_addr_in,
  input wire logic [7:0] smbus_data_in,
  // selected write
  output logic wr_en_out,
  output logic [7:0] wr_addr_out,
  output logic [7:0] wr_data_out
);
  // ==========================================================================
  // source select
  // in i2c mode only the eeprom loader writes, otherwise only the smbus host
  always_comb begin
    if (i2c_mode_in) begin
      wr_en_out = eeprom_wr_in;
      wr_addr_out = eeprom_addr_in;
      wr_data_out = eeprom_data_in;
    end else begin
      wr_en_out = smbus_wr_in;
      wr_addr_out = smbus_addr_in;
      wr_data_out = smbus_data_in;
    end
  end
endmodule // hpcr_wr_select
`default_nettype wire

// [hub_port_config_registers_tb.sv]
// hub_port_config_registers_tb: self-checking bench of the port config bank
`timescale 1ns/1ns
`default_nettype none
module hub_port_config_registers_tb;
  // ==========================================================================
  // clock, reset, straps, otp, mode
  logic clk_sys_in, arst_n_in, pol, otp_hicur, otp_auto, i2c_mode;
  logic [1:0] strap, otp_nrem, charge_out, rmbl_out;
  wire logic e_wr, s_wr, s_rd, rd_valid;
  wire logic [7:0] e_addr, e_data, s_addr, s_data, rd_data;
  logic [7:0] phy_out, cfg2_out;
  int bad_count = 0;
  int num_checks = 0;
  // 10 MHz clock
  initial begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  // ==========================================================================
  // bank and its host
  hpcr_host_model host_u (.clk_sys_in(clk_sys_in), .rd_data_in(rd_data),
    .rd_valid_in(rd_valid), .eeprom_wr_out(e_wr), .eeprom_addr_out(e_addr),
    .eeprom_data_out(e_data), .smbus_wr_out(s_wr), .smbus_rd_out(s_rd),
    .smbus_addr_out(s_addr), .smbus_data_out(s_data));
  hpcr_bank dut_u (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
    .power_charge_strap_pins_in(strap), .pwr_pol_strap_in(pol),
    .otp_non_removable_in(otp_nrem), .otp_hicur_in(otp_hicur),
    .otp_auto_dis_in(otp_auto), .i2c_mode_in(i2c_mode), .eeprom_wr_in(e_wr),
    .eeprom_addr_in(e_addr), .eeprom_data_in(e_data), .smbus_wr_in(s_wr),
    .smbus_rd_in(s_rd), .smbus_addr_in(s_addr), .smbus_data_in(s_data),
    .rd_data_out(rd_data), .rd_valid_out(rd_valid),
    .charge_port_enable_out(charge_out), .port_removable_out(rmbl_out),
    .phy_tuning_out(phy_out), .dev_cfg2_out(cfg2_out));
  // ==========================================================================
  // compare, read-and-compare, verdict
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] v;
    logic ok;
    host_u.rd(addr, v, ok);
    chk({7'h00, ok}, 8'h01);
    chk(v, exp);
  endtask
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // hang guard at 2000 cycles, far beyond the roughly 60 cycles the tests need
  initial begin
    #(2000 * 100);
    bad_count++;
    test_done;
  end
  // ==========================================================================
  // main sequence
  initial begin
    {arst_n_in, strap, pol, otp_nrem, otp_hicur, otp_auto, i2c_mode} = 9'b0_10_0_01_1_0_0;
    repeat (8) @(negedge clk_sys_in);
    arst_n_in = 1'b1;
    repeat (2) @(negedge clk_sys_in);
    chk({6'h00, charge_out}, 8'h02);
    rchk(8'h06, 8'h02);
    rchk(8'h07, 8'h02);
    chk({6'h00, rmbl_out}, 8'h02);
    rchk(8'h0a, 8'h30);
    host_u.wr(1'b0, 8'h06, 8'hff);
    rchk(8'h06, 8'h03);
    chk({6'h00, charge_out}, 8'h03);
    host_u.wr(1'b0, 8'h07, 8'h03); // override clear: bits locked
    rchk(8'h07, 8'h02);
    host_u.wr(1'b0, 8'h07, 8'h8d); // override with bits 3:2 poked
    rchk(8'h07, 8'h81);
    chk({6'h00, rmbl_out}, 8'h01);
    host_u.wr(1'b1, 8'h06, 8'h00); // loader ignored in smbus mode
    host_u.wr(1'b0, 8'h08, 8'hff);
    host_u.wr(1'b0, 8'h09, 8'hff);
    rchk(8'h08, 8'h00);
    rchk(8'h09, 8'h00);
    chk(phy_out, 8'h00);
    chk({6'h00, charge_out}, 8'h03);
    i2c_mode = 1'b1;
    host_u.wr(1'b0, 8'h06, 8'h00); // host ignored in i2c mode
    host_u.wr(1'b1, 8'h06, 8'h01);
    rchk(8'h06, 8'h01);
    host_u.wr(1'b1, 8'h0a, 8'hed);
    rchk(8'h0a, 8'h6c);
    host_u.wr(1'b1, 8'h0a, 8'h2c);
    rchk(8'h0a, 8'h3c);
    chk(cfg2_out, 8'h3c);
    host_u.wr(1'b1, 8'h07, 8'h00); // override back off
    otp_nrem = 2'h2;
    rchk(8'h07, 8'h01);
    rchk(8'h0b, 8'h00);
    test_done;
  end
endmodule // hub_port_config_registers_tb
`default_nettype wire
